//--- design/cpc_pkg.sv
/*
 Package for the channel power command block: command byte offsets, bit
 positions, timing constants, modes and carrier structs.
 Assumes one clock at 200 MHz and a byte-wide register write port.
*/
package cpc_pkg;

  localparam int NCH = 4;

  localparam logic [7:0] POWER_CMD_OFFSET = 8'h19;
  localparam logic [7:0] RESET_CMD_OFFSET = 8'h1a;

  localparam int PWR_ON_LSB  = 0;
  localparam int PWR_OFF_LSB = 4;

  localparam int RST_CHAN_LSB     = 0;
  localparam int RST_GLOBAL_BIT   = 4;
  localparam int RST_UNUSED_BIT   = 5;
  localparam int RST_RELEASE_BIT  = 6;
  localparam int RST_CLEARALL_BIT = 7;

  localparam logic [7:0] POLICE_OFF_VALUE = 8'hff;
  localparam logic [7:0] CMD_READ_VALUE   = 8'h00;
  localparam logic [2:0] MIN_HIGH_CLASS   = 3'h5;

  localparam int CLK_MHZ       = 200;
  localparam int CLEAR_TIME_US = 5000;
  localparam int CLEAR_CYCLES  = CLEAR_TIME_US * CLK_MHZ;
  localparam int RESTART_TIME_US = 3000;
  localparam int RESTART_CYCLES  = RESTART_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    CPC_MODE_OFF,
    CPC_MODE_MANUAL,
    CPC_MODE_SEMI,
    CPC_MODE_AUTO
  } cpc_mode_t;

  typedef enum logic [1:0] {
    CPC_CH_IDLE,
    CPC_CH_WAIT_CYCLE,
    CPC_CH_WAIT_CLASS,
    CPC_CH_ON
  } cpc_ch_state_t;

  // Engine status for one channel
  typedef struct packed {
    logic       detect_en;
    logic       class_en;
    logic       class_started;
    logic       class_done;
    logic       class_valid;
    logic       alloc_ok;
    logic       cooldown;
    logic [2:0] assigned_class;
  } cpc_ch_status_t;

  // Per-channel actions handed to the engines
  typedef struct packed {
    logic power_on;
    logic power_off;
    logic start_cycle;
    logic clear_regs;
    logic abort_cooldown;
  } cpc_ch_action_t;

endpackage

//--- design/cpc_channel.sv
/*
 One channel's power-on sequencing: in semi and auto modes waits for a detect/class cycle and then
 turns the channel on when class and allocation allow; manual mode turns it on at once, and a dual-signature side is restored without a new cycle.
 Assumes engine status is synchronous to i_clk.
*/
`timescale 1ns/1ps
module cpc_channel (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire cpc_pkg::cpc_mode_t      i_mode,
  input  wire cpc_pkg::cpc_ch_status_t i_status,
  input  wire logic                    i_on_cmd,
  input  wire logic                    i_off,
  input  wire logic                    i_peer_on,
  input  wire logic                    i_dual_sig,
  output logic                         o_on,
  output logic                         o_start_cycle
);
  import cpc_pkg::*;

  typedef struct packed {
    cpc_ch_state_t state;
    logic          start;
  } cpc_ch_reg_t;

  cpc_ch_reg_t st_reg;
  cpc_ch_reg_t st_next;
  logic        both_en;
  logic        grant;

  always_comb begin
    both_en = i_status.detect_en & i_status.class_en;
    grant   = i_status.class_done & i_status.class_valid & i_status.alloc_ok;
    st_next = st_reg;
    st_next.start = 1'b0;
    unique case (st_reg.state)
      CPC_CH_IDLE: begin
        // R4: auto mode powers after every valid cycle
        if (i_mode == CPC_MODE_AUTO && both_en && grant) begin
          st_next.state = CPC_CH_ON;
        end else if (i_on_cmd && !i_status.cooldown) begin
          if (i_mode == CPC_MODE_MANUAL) begin
            st_next.state = CPC_CH_ON;
          end else if (i_dual_sig && i_peer_on && i_status.class_valid
                       && i_status.alloc_ok) begin
            // R11: restore one side of a dual-signature port
            st_next.state = CPC_CH_ON;
          end else if (!both_en) begin
            // R1: R3: singular full detect and class cycle
            st_next.state = CPC_CH_WAIT_CLASS;
            st_next.start = 1'b1;
          end else if (i_mode == CPC_MODE_SEMI) begin
            // R2: join the next or current cycle
            st_next.state = i_status.class_started ? CPC_CH_WAIT_CYCLE
                                                   : CPC_CH_WAIT_CLASS;
          end
        end
      end
      CPC_CH_WAIT_CYCLE: begin
        // Current classing already running; power at its end if granted, else take the following one
        if (i_status.class_done) begin
          st_next.state = grant ? CPC_CH_ON : CPC_CH_WAIT_CLASS;
        end
      end
      CPC_CH_WAIT_CLASS: begin
        // R2: power right after class if valid and allocated
        if (i_status.class_done) begin
          st_next.state = grant ? CPC_CH_ON : CPC_CH_IDLE;
        end
      end
      CPC_CH_ON: begin
      end
    endcase
    // R24: cooldown blocks a pending turn on
    if (i_status.cooldown && st_reg.state != CPC_CH_ON) begin
      st_next.state = CPC_CH_IDLE;
    end
    // R7: power off wins at once
    if (i_off || i_mode == CPC_MODE_OFF) begin
      st_next.state = CPC_CH_IDLE;
      st_next.start = 1'b0;
    end
    if (!i_reset_n) begin
      st_next.state = CPC_CH_IDLE;
      st_next.start = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end

  assign o_on          = (st_reg.state == CPC_CH_ON);
  assign o_start_cycle = st_reg.start;

endmodule

//--- design/cpc_top.sv
/*
 Channel power command and reset command logic for one group of four
 channels. Decodes the power command byte and the reset command byte from
 the register write port and drives per-channel actions to the engines.
 Assumes the management bus front end gives a one-cycle write strobe with
 offset and data, and that engines report status synchronously.
*/
// How it works
// R1: semi mode, either enable clear: power-on runs one full detect and class cycle
// R2: semi mode, both enables: power after class if valid and allocation suffices
// R3: auto mode, either enable clear: command launches one cycle then powers
// R4: auto mode, both enables: channel turns on after each cycle unprompted
// R5: host programs allocation before power-on; later changes may be ignored
// R6: auto mode ignores a power-on to only one channel of a four-pair port
// R7: power-off disables at once, clears channel bits, policing set to all ones
// R8: clearing may take up to 5 ms; a busy flag covers it
// R9: only the targeted channel or port is cleared
// R10: power-off on one side of high-class single-signature port stops both
// R11: dual-signature side switched off may be restored by a new power-on
// R12: host should write both channels of a four-pair port together
// R13: reset byte bits trigger on one, ignore zero, and self clear
// R14: bit 7 clears all events and interrupts and releases the interrupt pin
// R15: bit 6 releases the interrupt pin only
// R16: after release the pin stays quiet until all interrupts are cleared
// R17: bit 4 resets the group except kept registers; undervoltage flags track supply
// R18: global reset acts only on this four-channel group
// R19: bits 3-0 turn off a channel and clear like power-off
// R20: channel reset on a four-pair port resets both channels
// R21: channel reset aborts any cooldown in progress
// R22: host waits 3 ms after channel reset before re-enabling
// R23: power-on and power-off together for one channel turns it off
// R24: power-on during cooldown is ignored and channel stays off
// R25: bit 5 does nothing; command bytes read as zero
`timescale 1ns/1ps
module cpc_top #(
  parameter int CLEAR_CNT   = cpc_pkg::CLEAR_CYCLES,
  parameter int RESTART_CNT = cpc_pkg::RESTART_CYCLES
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_reset_n,
  input  wire logic                              i_wr_en,
  input  wire logic [7:0]                        i_wr_addr,
  input  wire logic [7:0]                        i_wr_data,
  input  wire logic                              i_rd_en,
  input  wire cpc_pkg::cpc_mode_t                i_mode,
  input  wire logic [cpc_pkg::NCH/2-1:0]         i_four_pair,
  input  wire logic [cpc_pkg::NCH/2-1:0]         i_dual_sig,
  input  wire cpc_pkg::cpc_ch_status_t [cpc_pkg::NCH-1:0] i_status,
  input  wire logic                              i_irq_pending,
  input  wire logic                              i_logic_supply_uv,
  input  wire logic                              i_power_supply_uv,
  output logic [7:0]                             o_rd_data,
  output cpc_pkg::cpc_ch_action_t [cpc_pkg::NCH-1:0] o_action,
  output logic [cpc_pkg::NCH-1:0]                o_chan_enabled,
  output logic [7:0]                             o_police_fill,
  output logic                                   o_clear_all_events,
  output logic                                   o_global_reset,
  output logic                                   o_int_n,
  output logic [cpc_pkg::NCH-1:0]                o_clear_busy,
  output logic [cpc_pkg::NCH-1:0]                o_restart_hold,
  output logic                                   o_logic_supply_uv_flag,
  output logic                                   o_power_supply_uv_flag
);
  import cpc_pkg::*;

  localparam int CW = $clog2(RESTART_CNT > CLEAR_CNT ? RESTART_CNT + 1 : CLEAR_CNT + 1);

  typedef struct packed {
    cpc_ch_action_t [NCH-1:0] action;
    logic [NCH-1:0]           enabled;
    logic                     clear_all;
    logic                     global_rst;
    logic                     irq_muted;
    logic                     int_n;
    logic [7:0]               rd_data;
    logic [NCH-1:0][CW-1:0]   clr_cnt;
    logic [NCH-1:0][CW-1:0]   rst_cnt;
    logic [NCH-1:0]           clr_busy;
    logic [NCH-1:0]           rst_hold;
    logic                     luv;
    logic                     puv;
    logic [7:0]               fill;
  } cpc_state_t;

  cpc_state_t     st_reg;
  cpc_state_t     st_next;
  logic [NCH-1:0] ch_on;
  logic [NCH-1:0] ch_start;
  logic [NCH-1:0] on_cmd;
  logic [NCH-1:0] off_cmd;
  logic [NCH-1:0] chan_rst;
  logic [NCH-1:0] kill;
  logic [NCH-1:0] peer_on;
  logic [NCH-1:0] peer_fp;
  logic [NCH-1:0] peer_dual;
  logic           pwr_wr;
  logic           rst_wr;

  // Four-pair pairing: channel n shares a port with n xor 1
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      peer_fp[i]   = i_four_pair[i/2];
      peer_dual[i] = i_dual_sig[i/2];
      peer_on[i]   = ch_on[i ^ 1];
    end
  end

  always_comb begin
    pwr_wr = i_wr_en && (i_wr_addr == POWER_CMD_OFFSET);
    rst_wr = i_wr_en && (i_wr_addr == RESET_CMD_OFFSET);
    on_cmd   = '0;
    off_cmd  = '0;
    chan_rst = '0;
    for (int i = 0; i < NCH; i++) begin
      // R13: only one bits act
      if (pwr_wr) begin
        on_cmd[i]  = i_wr_data[PWR_ON_LSB + i];
        off_cmd[i] = i_wr_data[PWR_OFF_LSB + i];
      end
      if (rst_wr) begin
        chan_rst[i] = i_wr_data[RST_CHAN_LSB + i] | i_wr_data[RST_GLOBAL_BIT];
      end
    end
    for (int i = 0; i < NCH; i++) begin
      if (peer_fp[i]) begin
        // R6: singular power-on ignored in auto mode
        if (i_mode == CPC_MODE_AUTO && !on_cmd[i ^ 1]) begin
          on_cmd[i] = 1'b0;
        end
        // R20: channel reset hits both channels of port
        if (rst_wr && i_wr_data[RST_CHAN_LSB + (i ^ 1)]) begin
          chan_rst[i] = 1'b1;
        end
        // R10: high-class single signature stops both
        if (!peer_dual[i] && off_cmd[i ^ 1] &&
            i_status[i ^ 1].assigned_class >= MIN_HIGH_CLASS) begin
          off_cmd[i] = 1'b1;
        end
      end
    end
    // R23: off wins over on in the same write
    on_cmd = on_cmd & ~off_cmd & ~chan_rst;
    // R9: R19: kill only targeted channels
    kill = off_cmd | chan_rst;
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    cpc_channel u_ch (
      .i_clk         (i_clk),
      .i_reset_n     (i_reset_n),
      .i_mode        (i_mode),
      .i_status      (i_status[g]),
      .i_on_cmd      (on_cmd[g]),
      .i_off         (kill[g]),
      .i_peer_on     (peer_on[g]),
      .i_dual_sig    (peer_dual[g]),
      .o_on          (ch_on[g]),
      .o_start_cycle (ch_start[g])
    );
  end

  always_comb begin
    st_next = st_reg;
    st_next.enabled = ch_on;
    st_next.rd_data = CMD_READ_VALUE;
    // R7: policing threshold value on clear
    st_next.fill    = POLICE_OFF_VALUE;
    // R17: undervoltage flags keep tracking supply
    st_next.luv = i_logic_supply_uv;
    st_next.puv = i_power_supply_uv;
    // R13: command pulses self clear
    st_next.clear_all  = rst_wr & i_wr_data[RST_CLEARALL_BIT];
    // R17: R18: global reset of this group only
    st_next.global_rst = rst_wr & i_wr_data[RST_GLOBAL_BIT];
    for (int i = 0; i < NCH; i++) begin
      st_next.action[i].power_on    = ch_on[i] & ~st_reg.enabled[i];
      // R7: disable and clear channel bits
      st_next.action[i].power_off   = kill[i];
      st_next.action[i].clear_regs  = kill[i];
      st_next.action[i].start_cycle = ch_start[i];
      // R21: channel reset aborts cooldown
      st_next.action[i].abort_cooldown = chan_rst[i];
      // R8: busy window while clearing completes
      if (kill[i]) begin
        st_next.clr_cnt[i]  = CW'(CLEAR_CNT);
        st_next.clr_busy[i] = 1'b1;
      end else if (st_reg.clr_cnt[i] != '0) begin
        st_next.clr_cnt[i]  = st_reg.clr_cnt[i] - CW'(1);
        st_next.clr_busy[i] = (st_reg.clr_cnt[i] != CW'(1));
      end
      // R22: restart hold after channel reset
      if (chan_rst[i]) begin
        st_next.rst_cnt[i]  = CW'(RESTART_CNT);
        st_next.rst_hold[i] = 1'b1;
      end else if (st_reg.rst_cnt[i] != '0) begin
        st_next.rst_cnt[i]  = st_reg.rst_cnt[i] - CW'(1);
        st_next.rst_hold[i] = (st_reg.rst_cnt[i] != CW'(1));
      end
    end
    // R16: muted until pending interrupts drain; a bit 7 or bit 4 unmute wins over a bit 6 set
    if (!i_irq_pending) begin
      st_next.irq_muted = 1'b0;
    end
    // R15: release pin only
    if (rst_wr && i_wr_data[RST_RELEASE_BIT] && i_irq_pending) begin
      st_next.irq_muted = 1'b1;
    end
    // R14: clear all also releases pin
    if (rst_wr && (i_wr_data[RST_CLEARALL_BIT] || i_wr_data[RST_GLOBAL_BIT])) begin
      st_next.irq_muted = 1'b0;
    end
    st_next.int_n = ~(i_irq_pending & ~st_next.irq_muted &
                      ~(rst_wr & (i_wr_data[RST_CLEARALL_BIT] |
                                  i_wr_data[RST_RELEASE_BIT])));
    // R25: bit 5 is ignored by all decoding above
    if (!i_reset_n) begin
      st_next = '0;
      st_next.int_n = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end

  assign o_rd_data              = st_reg.rd_data;
  assign o_action               = st_reg.action;
  assign o_chan_enabled         = st_reg.enabled;
  assign o_police_fill          = st_reg.fill;
  assign o_clear_all_events     = st_reg.clear_all;
  assign o_global_reset         = st_reg.global_rst;
  assign o_int_n                = st_reg.int_n;
  assign o_clear_busy           = st_reg.clr_busy;
  assign o_restart_hold         = st_reg.rst_hold;
  assign o_logic_supply_uv_flag = st_reg.luv;
  assign o_power_supply_uv_flag = st_reg.puv;

endmodule

//--- bench/cpc_top_checker.sv
/*
 Concurrent checks on the command decode, pulses, clear busy timer and pin mute.
 Assumes binding to cpc_top, with CLEAR_CNT handed on from the design.
*/
`timescale 1ns/1ps
module cpc_top_checker #(
  parameter int CLEAR_CNT = 8
) (
  input wire logic                       i_clk,
  input wire logic                       i_reset_n,
  input wire logic                       i_wr_en,
  input wire logic [7:0]                 i_wr_addr,
  input wire logic [7:0]                 i_wr_data,
  input wire logic [1:0]                 i_four_pair,
  input wire logic                       i_irq_pending,
  input wire cpc_pkg::cpc_ch_action_t [3:0] o_action,
  input wire logic [3:0]                 o_chan_enabled,
  input wire logic [7:0]                 o_police_fill,
  input wire logic                       o_clear_all_events,
  input wire logic                       o_global_reset,
  input wire logic                       o_int_n,
  input wire logic [3:0]                 o_clear_busy
);
  import cpc_pkg::*;
  logic rst_wr;
  logic pwr_wr;
  int   busy_cnt;
  assign rst_wr = i_wr_en && i_wr_addr == RESET_CMD_OFFSET;
  assign pwr_wr = i_wr_en && i_wr_addr == POWER_CMD_OFFSET;
  // Length of the clearing window, counted in high samples
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !o_clear_busy[0]) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence muted_s;
    rst_wr && i_wr_data[RST_RELEASE_BIT] && i_irq_pending ##1 i_irq_pending [*2];
  endsequence
  chan_kill_a: assert property (rst_wr && i_wr_data[0] |=> o_action[0].power_off
    && o_action[0].clear_regs && o_action[0].abort_cooldown) else $error("channel reset lost");
  pair_kill_a: assert property (rst_wr && i_wr_data[1] && i_four_pair[0]
    |=> o_action[0].power_off) else $error("pair partner not reset");
  clear_all_a: assert property (rst_wr && i_wr_data[7] |=> o_clear_all_events)
    else $error("clear all pulse missing");
  global_rst_a: assert property (rst_wr && i_wr_data[4] |=> o_global_reset)
    else $error("global reset pulse missing");
  self_clear_a: assert property (!(rst_wr && i_wr_data[4]) |=> !o_global_reset)
    else $error("global reset pulse not self clearing");
  bit_five_a: assert property (rst_wr && i_wr_data == 8'h20
    |=> !o_clear_all_events && !o_global_reset) else $error("spare bit had effect");
  on_off_a: assert property (pwr_wr && i_wr_data[0] && i_wr_data[4]
    |=> ##1 !o_chan_enabled[0]) else $error("on plus off left channel on");
  fill_val_a: assert property (o_action[0].clear_regs |-> o_police_fill == POLICE_OFF_VALUE)
    else $error("policing fill value wrong");
  busy_len_a: assert property ($fell(o_clear_busy[0]) |-> busy_cnt == CLEAR_CNT)
    else $error("clear busy length wrong");
  pin_mute_a: assert property (muted_s |-> o_int_n)
    else $error("interrupt pin not released");
  power_on_a: assert property ($rose(o_chan_enabled[0]) |-> o_action[0].power_on)
    else $error("power on pulse missing");
endmodule

bind cpc_top cpc_top_checker #(.CLEAR_CNT(CLEAR_CNT)) chk_u (.i_clk, .i_reset_n, .i_wr_en,
  .i_wr_addr, .i_wr_data, .i_four_pair, .i_irq_pending, .o_action, .o_chan_enabled,
  .o_police_fill, .o_clear_all_events, .o_global_reset, .o_int_n, .o_clear_busy);

//--- bench/cpc_engine_model.sv
/*
 Detection and classification engines for four channels, behavioural.
 Assumes the bench sets enables, cooldown and class as levels.
*/
`timescale 1ns/1ps
module cpc_engine_model (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  input  wire cpc_pkg::cpc_ch_action_t [3:0] i_action,
  input  wire logic [3:0]                    i_en,
  input  wire logic [3:0]                    i_cool,
  input  wire logic [2:0]                    i_cls,
  output cpc_pkg::cpc_ch_status_t [3:0]      o_status
);
  import cpc_pkg::*;
  logic [3:0] cnt_reg [4];
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < 4; c++) begin
      // one pass on request, free running with both enables
      if (!i_reset_n) cnt_reg[c] <= 4'h0;
      else if (i_action[c].start_cycle || (i_en[c] && cnt_reg[c] == 4'h0)) cnt_reg[c] <= 4'h9;
      else if (cnt_reg[c] != 4'h0) cnt_reg[c] <= cnt_reg[c] - 4'h1;
    end
  end
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      // allocation settled before commands; cooldown from bench
      o_status[c] = {i_en[c], i_en[c], cnt_reg[c] inside {[1:5]}, cnt_reg[c] == 4'h1,
                     1'b1, 1'b1, i_cool[c], i_cls};
    end
  end
endmodule

//--- bench/channel_power_command_reset_test.sv
/*
 Self-checking bench for cpc_top with queued expected pulses.
 Assumes short clear and restart counts and the engine model.
*/
`timescale 1ns/1ps
module channel_power_command_reset_test;
  import cpc_pkg::*;
  logic i_clk, i_reset_n, i_wr_en, i_rd_en, i_irq_pending;
  logic i_logic_supply_uv, i_power_supply_uv, o_clear_all_events, o_global_reset, o_int_n;
  logic o_logic_supply_uv_flag, o_power_supply_uv_flag;
  logic [7:0] i_wr_addr, i_wr_data, o_rd_data, o_police_fill;
  logic [1:0] i_four_pair, i_dual_sig;
  logic [3:0] o_chan_enabled, o_clear_busy, o_restart_hold, i_en, i_cool, off;
  logic [2:0] i_cls;
  cpc_mode_t i_mode;
  cpc_ch_status_t [3:0] i_status;
  cpc_ch_action_t [3:0] o_action;
  logic [5:0] expq [$];
  logic [7:0] gv [3] = '{8'h80, 8'h10, 8'h90};
  logic [5:0] ge [3] = '{6'h20, 6'h1f, 6'h3f};
  int error_cnt = 0;
  int compares = 0;
  cpc_top #(.CLEAR_CNT(8), .RESTART_CNT(12)) dut_u (.i_clk, .i_reset_n, .i_wr_en, .i_wr_addr,
    .i_wr_data, .i_rd_en, .i_mode, .i_four_pair, .i_dual_sig, .i_status, .i_irq_pending,
    .i_logic_supply_uv, .i_power_supply_uv, .o_rd_data, .o_action, .o_chan_enabled,
    .o_police_fill, .o_clear_all_events, .o_global_reset, .o_int_n, .o_clear_busy,
    .o_restart_hold, .o_logic_supply_uv_flag, .o_power_supply_uv_flag);
  cpc_engine_model mdl_u (.i_clk, .i_reset_n, .i_action(o_action), .i_en, .i_cool, .i_cls,
    .o_status(i_status));
  always #2.5 i_clk = ~i_clk;
  always_comb for (int c = 0; c < 4; c++) off[c] = o_action[c].power_off;
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    chk("queue", 8'(expq.size()), 8'h00);
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    i_wr_en = 1'b1; i_wr_addr = a; i_wr_data = d;
    @(posedge i_clk) #1;
    i_wr_en = 1'b0;
  endtask
  task automatic wait_en(input int c, input logic v);
    for (int i = 0; i < 40 && o_chan_enabled[c] !== v; i++) @(posedge i_clk) #1;
    chk("enabled", {7'h0, o_chan_enabled[c]}, {7'h0, v});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk) #1;
  endtask
  function automatic logic [3:0] pairs(input logic [3:0] m);
    for (int p = 0; p < 2; p++) if (i_four_pair[p] && |m[2*p+:2]) m[2*p+:2] = 2'b11;
    return m;
  endfunction
  // Every clear-all, global reset and power-off pulse must match the oldest queued expectation
  always @(posedge i_clk) begin
    #2;
    if (i_reset_n && {o_clear_all_events, o_global_reset, off} !== 6'h0)
      chk("pulses", {2'b00, o_clear_all_events, o_global_reset, off},
          {2'b00, (expq.size() ? expq.pop_front() : 6'h0)});
  end
  initial begin
    #50000;
    error_cnt++;
    conclude();
  end
  initial begin
    logic [3:0] m;
    logic [1:0] uv;
    {i_clk, i_reset_n, i_wr_en, i_rd_en, i_irq_pending, i_logic_supply_uv} = '0;
    {i_power_supply_uv, i_wr_addr, i_wr_data, i_four_pair, i_dual_sig} = '0;
    {i_en, i_cool} = '0;
    i_cls = 3'h4;
    i_mode = CPC_MODE_MANUAL;
    void'($urandom(84));
    idle(12);
    i_reset_n = 1'b1;
    i_rd_en = 1'b1;
    idle(1);
    chk("read", o_rd_data, CMD_READ_VALUE);
    i_rd_en = 1'b0;
    wr(RESET_CMD_OFFSET, 8'h20);
    wr(POWER_CMD_OFFSET, 8'h01);
    wait_en(0, 1'b1);
    expq.push_back(6'h01);
    wr(POWER_CMD_OFFSET, 8'h11);
    idle(1);
    chk("enabled", {4'h0, o_chan_enabled}, 8'h00);
    i_irq_pending = 1'b1;
    idle(3);
    chk("int", {7'h0, o_int_n}, 8'h00);
    wr(RESET_CMD_OFFSET, 8'h40);
    idle(2);
    chk("int", {7'h0, o_int_n}, 8'h01);
    i_irq_pending = 1'b0;
    idle(2);
    i_irq_pending = 1'b1;
    idle(3);
    chk("int", {7'h0, o_int_n}, 8'h00);
    i_irq_pending = 1'b0;
    repeat (6) begin
      i_four_pair = 2'($urandom);
      i_dual_sig = 2'($urandom);
      i_cls = 3'($urandom);
      m = 4'($urandom);
      if (m == 4'h0) m = 4'h8;
      expq.push_back({2'b00, pairs(m)});
      wr(RESET_CMD_OFFSET, {4'h0, m});
      chk("hold", {4'h0, o_restart_hold}, {4'h0, pairs(m)});
      chk("busy", {4'h0, o_clear_busy}, {4'h0, pairs(m)});
      idle(14);
      chk("hold", {4'h0, o_restart_hold}, 8'h00);
    end
    uv = 2'($urandom);
    {i_logic_supply_uv, i_power_supply_uv} = uv;
    foreach (gv[k]) begin
      expq.push_back(ge[k]);
      wr(RESET_CMD_OFFSET, gv[k]);
      idle(14);
    end
    chk("uv", {6'h0, o_logic_supply_uv_flag, o_power_supply_uv_flag}, {6'h0, uv});
    {i_logic_supply_uv, i_power_supply_uv} = ~uv;
    idle(2);
    chk("uv", {6'h0, o_logic_supply_uv_flag, o_power_supply_uv_flag}, {6'h0, ~uv});
    {i_four_pair, i_dual_sig} = 4'h0;
    i_mode = CPC_MODE_SEMI;
    wr(POWER_CMD_OFFSET, 8'h04);
    wait_en(2, 1'b1);
    i_mode = CPC_MODE_AUTO;
    i_four_pair = 2'b01;
    i_cls = MIN_HIGH_CLASS;
    wr(POWER_CMD_OFFSET, 8'h01);
    idle(30);
    chk("enabled", {7'h0, o_chan_enabled[0]}, 8'h00);
    wr(POWER_CMD_OFFSET, 8'h03);
    wait_en(0, 1'b1);
    wait_en(1, 1'b1);
    expq.push_back(6'h03);
    wr(POWER_CMD_OFFSET, 8'h10);
    wait_en(1, 1'b0);
    idle(14);
    i_mode = CPC_MODE_SEMI;
    {i_dual_sig, i_cls} = {2'b01, 3'h4};
    wr(POWER_CMD_OFFSET, 8'h03);
    wait_en(1, 1'b1);
    expq.push_back(6'h01);
    wr(POWER_CMD_OFFSET, 8'h10);
    wait_en(0, 1'b0);
    chk("enabled", {7'h0, o_chan_enabled[1]}, 8'h01);
    wr(POWER_CMD_OFFSET, 8'h01);
    wait_en(0, 1'b1);
    i_mode = CPC_MODE_MANUAL;
    {i_four_pair, i_cool} = {2'b00, 4'h8};
    wr(POWER_CMD_OFFSET, 8'h08);
    idle(20);
    chk("enabled", {7'h0, o_chan_enabled[3]}, 8'h00);
    expq.push_back(6'h08);
    wr(RESET_CMD_OFFSET, 8'h08);
    idle(14);
    i_mode = CPC_MODE_AUTO;
    {i_cool, i_en} = 8'h08;
    wait_en(3, 1'b1);
    idle(4);
    // Off mode forces every channel down
    i_mode = CPC_MODE_OFF;
    idle(3);
    chk("enabled", {4'h0, o_chan_enabled}, 8'h00);
    conclude();
  end
endmodule
